// File: iem_map.svh
`ifndef IEM_MAP_SVH
`define IEM_MAP_SVH
// Summary of operation
// - writing read-go with 1 fetches the addressed word into the read-data pair
// - upper read-data word holds bits 31..16, lower word holds bits 15..0
// - read-done flag in read status lets the host poll for completion
// - read-done is bit 0 of read status; host polls it or waits
// - shadow reads finish one clock after the synchronised request
// - write-go stores the 32-bit word at the write address, then sets write-done
// - shadow copies use the same sequences at extended address plus 0x20
// - trim locations 0x07 to 0x12 stay writable by the customer
// - power modes 3 to 6 limit serial access to a few direct registers
// - in those modes only direct addresses 0x32-0x33 accept writes
// - readable then: 0x12-0x2B and 0x32-0x33 on I2C, 0x1C-0x2A and 0x32-0x33 on SPI
// - nonvolatile and test space reachable only through the indirect registers
// - write-go (bit 15) sets write-busy, clears write-done, reads back 0
// - read-go (bit 15) sets read-busy at bit 8, clears read-done, reads back 0

// ****************************************
// direct byte addresses
// ****************************************
`define IEM_A_NOP 6'h00
`define IEM_A_WR_ADDR 6'h02
`define IEM_A_WR_DATA_HI 6'h04
`define IEM_A_WR_DATA_LO 6'h06
`define IEM_A_WR_CTRL 6'h08
`define IEM_A_RD_ADDR 6'h0a
`define IEM_A_RD_CTRL 6'h0c
`define IEM_A_RD_DATA_HI 6'h0e
`define IEM_A_RD_DATA_LO 6'h10
`define IEM_A_CTRL_ONE 6'h32
`define IEM_A_LOOPBACK 6'h34
`define IEM_A_CTRL_TWO 6'h36
`define IEM_A_CTRL_THREE 6'h38
`define IEM_A_CTRL_FOUR 6'h3a
`define IEM_A_RESERVED 6'h3c
`define IEM_A_KEY 6'h3e

// ****************************************
// fields and reset values
// ****************************************
`define IEM_GO_BIT 15
`define IEM_BUSY_BIT 8
`define IEM_DONE_BIT 0
`define IEM_MODE_LSB 0
`define IEM_MODE_MSB 2
`define IEM_LP_MODE_MIN 3'h3
`define IEM_LP_MODE_MAX 3'h6
`define IEM_RST_WORD 16'h0000
`define IEM_RST_BYTE 8'h00
`define IEM_RST_EXT 32'h0000_0000

// ****************************************
// extended space
// ****************************************
`define IEM_SHADOW_OFS 8'h20
`define IEM_TRIM_FIRST 8'h07
`define IEM_TRIM_LAST 8'h12
`define IEM_EXT_DEPTH 256

// ****************************************
// low-power read windows
// ****************************************
`define IEM_LP_I2C_LO 6'h12
`define IEM_LP_I2C_HI 6'h2b
`define IEM_LP_SPI_LO 6'h1c
`define IEM_LP_SPI_HI 6'h2a

// ****************************************
// timing
// ****************************************
`define IEM_CLK_NS 10
`define IEM_EE_READ_NS 100
`define IEM_EE_WRITE_NS 10000
`define IEM_EE_READ_CYC ((`IEM_EE_READ_NS + `IEM_CLK_NS - 1) / `IEM_CLK_NS)
`define IEM_EE_WRITE_CYC ((`IEM_EE_WRITE_NS + `IEM_CLK_NS - 1) / `IEM_CLK_NS)
`endif

// File: iem_pkg.sv
package iem_pkg;
   typedef logic [5:0] iem_addr_t;
   typedef logic [7:0] iem_ext_addr_t;
   typedef logic [31:0] iem_word_t;
   typedef enum logic [1:0] {
      IEM_MEM_IDLE = 2'b00,
      IEM_MEM_WAIT = 2'b01,
      IEM_MEM_ACK = 2'b10
   } iem_mem_state_e;
endpackage

// File: iem_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
interface iem_mem_if;
   import iem_pkg::*;
   logic ready;
   logic req;
   logic we;
   iem_ext_addr_t addr;
   iem_word_t wdata;
   logic ack;
   iem_word_t rdata;
   modport ctrl (input ready, output req, output we, output addr, output wdata, input ack,
      input rdata);
   modport mem (output ready, input req, input we, input addr, input wdata, output ack,
      output rdata);
endinterface
`default_nettype wire

// File: iem_ext_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "iem_map.svh"
module iem_ext_mem (
   input wire logic clk,
   input wire logic reset_n,
   iem_mem_if.mem port
);
   import iem_pkg::*;

   localparam logic [15:0] READ_CYC = 16'(`IEM_EE_READ_CYC);
   localparam logic [15:0] WRITE_CYC = 16'(`IEM_EE_WRITE_CYC);

   iem_word_t ext_array [0:`IEM_EXT_DEPTH-1];
   iem_mem_state_e state;
   logic [15:0] wait_cnt;
   logic op_we;
   iem_ext_addr_t op_addr;
   iem_word_t op_wdata;
   logic slow;

   // eeprom cells sit below the shadow copies; everything above answers at once
   assign slow = (port.addr < `IEM_SHADOW_OFS);
   assign port.ready = (state == IEM_MEM_IDLE);

   // ****************************************
   // sequencing
   // ****************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= IEM_MEM_IDLE;
         wait_cnt <= 16'h0000;
         op_we <= 1'b0;
         op_addr <= 8'h00;
         op_wdata <= `IEM_RST_EXT;
      end else begin
         unique case (state)
            IEM_MEM_IDLE: begin
               if (port.req) begin
                  op_we <= port.we;
                  op_addr <= port.addr;
                  op_wdata <= port.wdata;
                  // shadow and diagnostic words answer on the next edge
                  if (slow) begin
                     wait_cnt <= port.we ? WRITE_CYC : READ_CYC;
                     state <= IEM_MEM_WAIT;
                  end else begin
                     state <= IEM_MEM_ACK;
                  end
               end
            end
            IEM_MEM_WAIT: begin
               if (wait_cnt <= 16'h0001) begin
                  state <= IEM_MEM_ACK;
               end else begin
                  wait_cnt <= wait_cnt - 16'h0001;
               end
            end
            IEM_MEM_ACK: begin
               state <= IEM_MEM_IDLE;
            end
            default: begin
               state <= IEM_MEM_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // storage
   // ****************************************
   // no lock on the trim words: customer end-of-line adjustment may rewrite them
   always_ff @(posedge clk) begin
      if (state == IEM_MEM_ACK && op_we) begin
         ext_array[op_addr] <= op_wdata;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         port.ack <= 1'b0;
         port.rdata <= `IEM_RST_EXT;
      end else begin
         port.ack <= (state != IEM_MEM_ACK) && (state == IEM_MEM_WAIT ? wait_cnt <= 16'h0001
            : state == IEM_MEM_IDLE && port.req && !slow);
         if (!op_we || (state == IEM_MEM_IDLE && port.req && !port.we)) begin
            port.rdata <= ext_array[state == IEM_MEM_IDLE ? port.addr : op_addr];
         end
      end
   end
endmodule // iem_ext_mem
`default_nettype wire

// File: iem_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "iem_map.svh"
module iem_top (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic spi_mode,
   input wire logic reg_write,
   input wire iem_pkg::iem_addr_t reg_write_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_read,
   input wire iem_pkg::iem_addr_t reg_read_addr,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   output logic [2:0] power_mode_select,
   output logic ext_write_busy,
   output logic ext_read_busy
);
   import iem_pkg::*;

   iem_mem_if mem_bus ();

   iem_ext_mem u_mem (
      .clk(clk),
      .reset_n(reset_n),
      .port(mem_bus.mem)
   );

   // ****************************************
   // register state
   // ****************************************
   iem_ext_addr_t ext_write_address;
   iem_word_t ext_write_data;
   iem_ext_addr_t ext_read_address;
   iem_word_t ext_read_data;
   logic ext_write_done;
   logic ext_read_done;
   logic [15:0] device_control_one;
   logic [15:0] loopback_select;
   logic [15:0] device_control_two;
   logic [15:0] device_control_three;
   logic [15:0] device_control_four;
   logic [15:0] unlock_key;
   logic write_issued;
   logic read_issued;
   logic serving_write;

   logic low_power;
   logic write_ok;
   logic ext_write_go;
   logic ext_read_go;
   logic read_ok;
   logic [15:0] next_rdata;
   iem_addr_t wa;
   iem_addr_t ra;

   assign power_mode_select = device_control_one[`IEM_MODE_MSB:`IEM_MODE_LSB];
   assign low_power = (power_mode_select >= `IEM_LP_MODE_MIN)
      && (power_mode_select <= `IEM_LP_MODE_MAX);

   // the word-aligned address selects both byte lanes of one register
   assign wa = {reg_write_addr[5:1], 1'b0};
   assign ra = {reg_read_addr[5:1], 1'b0};

   // only the first control word stays writable when asleep
   assign write_ok = reg_write && (!low_power || wa == `IEM_A_CTRL_ONE);

   // go bits sit in the high byte, so only an even-address write can start one
   assign ext_write_go = write_ok && reg_write_addr == `IEM_A_WR_CTRL
      && reg_wdata[`IEM_GO_BIT-8];
   assign ext_read_go = write_ok && reg_write_addr == `IEM_A_RD_CTRL
      && reg_wdata[`IEM_GO_BIT-8];

   // ****************************************
   // byte writes to plain registers
   // ****************************************
   // the nonvolatile and test space has no direct path; it is reached only below
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ext_write_address <= `IEM_RST_BYTE;
         ext_write_data <= `IEM_RST_EXT;
         ext_read_address <= `IEM_RST_BYTE;
      end else if (write_ok) begin
         unique case (reg_write_addr)
            `IEM_A_WR_ADDR + 6'h01: ext_write_address <= reg_wdata;
            `IEM_A_WR_DATA_HI: ext_write_data[31:24] <= reg_wdata;
            `IEM_A_WR_DATA_HI + 6'h01: ext_write_data[23:16] <= reg_wdata;
            `IEM_A_WR_DATA_LO: ext_write_data[15:8] <= reg_wdata;
            `IEM_A_WR_DATA_LO + 6'h01: ext_write_data[7:0] <= reg_wdata;
            `IEM_A_RD_ADDR + 6'h01: ext_read_address <= reg_wdata;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         device_control_one <= `IEM_RST_WORD;
         loopback_select <= `IEM_RST_WORD;
         device_control_two <= `IEM_RST_WORD;
         device_control_three <= `IEM_RST_WORD;
         device_control_four <= `IEM_RST_WORD;
         unlock_key <= `IEM_RST_WORD;
      end else if (write_ok) begin
         unique case (wa)
            `IEM_A_CTRL_ONE: begin
               if (reg_write_addr[0]) device_control_one[7:0] <= reg_wdata;
               else device_control_one[15:8] <= reg_wdata;
            end
            `IEM_A_LOOPBACK: begin
               if (reg_write_addr[0]) loopback_select[7:0] <= reg_wdata;
               else loopback_select[15:8] <= reg_wdata;
            end
            `IEM_A_CTRL_TWO: begin
               if (reg_write_addr[0]) device_control_two[7:0] <= reg_wdata;
               else device_control_two[15:8] <= reg_wdata;
            end
            `IEM_A_CTRL_THREE: begin
               if (reg_write_addr[0]) device_control_three[7:0] <= reg_wdata;
               else device_control_three[15:8] <= reg_wdata;
            end
            `IEM_A_CTRL_FOUR: begin
               if (reg_write_addr[0]) device_control_four[7:0] <= reg_wdata;
               else device_control_four[15:8] <= reg_wdata;
            end
            `IEM_A_KEY: begin
               if (reg_write_addr[0]) unlock_key[7:0] <= reg_wdata;
               else unlock_key[15:8] <= reg_wdata;
            end
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // extended write handshake
   // ****************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ext_write_busy <= 1'b0;
         ext_write_done <= 1'b0;
      end else if (ext_write_go && !ext_write_busy) begin
         ext_write_busy <= 1'b1;
         ext_write_done <= 1'b0;
      end else if (mem_bus.ack && serving_write) begin
         // busy and done swap in one edge so they never overlap
         ext_write_busy <= 1'b0;
         ext_write_done <= 1'b1;
      end
   end

   // ****************************************
   // extended read handshake
   // ****************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ext_read_busy <= 1'b0;
         ext_read_done <= 1'b0;
      end else if (ext_read_go && !ext_read_busy) begin
         ext_read_busy <= 1'b1;
         ext_read_done <= 1'b0;
      end else if (mem_bus.ack && !serving_write && read_issued) begin
         ext_read_busy <= 1'b0;
         ext_read_done <= 1'b1;
      end
   end

   // the read-data pair changes only on completion; a host reading it earlier
   // may see a torn word
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ext_read_data <= `IEM_RST_EXT;
      end else if (mem_bus.ack && !serving_write && read_issued) begin
         ext_read_data <= mem_bus.rdata;
      end
   end

   // ****************************************
   // memory request issue
   // ****************************************
   // remembers which direction the memory works on, so its ack reaches the right flags
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         serving_write <= 1'b0;
      end else if (mem_bus.req) begin
         serving_write <= mem_bus.we;
      end
   end

   // one access at a time; a pending write goes before a pending read
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         write_issued <= 1'b0;
         read_issued <= 1'b0;
      end else begin
         if (mem_bus.req && mem_bus.we) begin
            write_issued <= 1'b1;
         end else if (mem_bus.ack && serving_write) begin
            write_issued <= 1'b0;
         end
         if (mem_bus.req && !mem_bus.we) begin
            read_issued <= 1'b1;
         end else if (mem_bus.ack && !serving_write) begin
            read_issued <= 1'b0;
         end
      end
   end

   always_comb begin
      mem_bus.req = 1'b0;
      mem_bus.we = 1'b0;
      mem_bus.addr = ext_read_address;
      mem_bus.wdata = ext_write_data;
      if (mem_bus.ready && !write_issued && !read_issued && !mem_bus.ack) begin
         if (ext_write_busy) begin
            mem_bus.req = 1'b1;
            mem_bus.we = 1'b1;
            mem_bus.addr = ext_write_address;
         end else if (ext_read_busy) begin
            mem_bus.req = 1'b1;
         end
      end
   end

   // ****************************************
   // interface strap synchroniser
   // ****************************************
   // the strap may move at any time; it only steers the low-power read window,
   // so a few cycles of latency cost nothing
   logic [2:0] spi_sync;
   logic spi_mode_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         spi_sync <= 3'h0;
      end else begin
         spi_sync <= {spi_sync[1:0], spi_mode};
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         spi_mode_q <= 1'b0;
      end else if (spi_sync[1] == spi_sync[2]) begin
         spi_mode_q <= spi_sync[2];
      end
   end

   // ****************************************
   // register reads
   // ****************************************
   always_comb begin
      read_ok = 1'b1;
      if (low_power) begin
         if (spi_mode_q) begin
            read_ok = (ra >= `IEM_LP_SPI_LO && ra <= `IEM_LP_SPI_HI) || ra == `IEM_A_CTRL_ONE;
         end else begin
            read_ok = (ra >= `IEM_LP_I2C_LO && ra <= `IEM_LP_I2C_HI) || ra == `IEM_A_CTRL_ONE;
         end
      end
   end

   always_comb begin
      next_rdata = `IEM_RST_WORD;
      unique case (ra)
         `IEM_A_WR_ADDR: next_rdata = {8'h00, ext_write_address};
         `IEM_A_WR_DATA_HI: next_rdata = ext_write_data[31:16];
         `IEM_A_WR_DATA_LO: next_rdata = ext_write_data[15:0];
         // go bits always read back as zero
         `IEM_A_WR_CTRL: next_rdata = {7'h00, ext_write_busy, 7'h00, ext_write_done};
         `IEM_A_RD_ADDR: next_rdata = {8'h00, ext_read_address};
         `IEM_A_RD_CTRL: next_rdata = {7'h00, ext_read_busy, 7'h00, ext_read_done};
         `IEM_A_RD_DATA_HI: next_rdata = ext_read_data[31:16];
         `IEM_A_RD_DATA_LO: next_rdata = ext_read_data[15:0];
         `IEM_A_CTRL_ONE: next_rdata = device_control_one;
         `IEM_A_LOOPBACK: next_rdata = loopback_select;
         `IEM_A_CTRL_TWO: next_rdata = device_control_two;
         `IEM_A_CTRL_THREE: next_rdata = device_control_three;
         `IEM_A_CTRL_FOUR: next_rdata = device_control_four;
         `IEM_A_KEY: next_rdata = unlock_key;
         default: next_rdata = `IEM_RST_WORD;
      endcase
   end

   // a refused read returns zeros rather than stale data
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= `IEM_RST_WORD;
      end else if (reg_read) begin
         reg_rdata <= read_ok ? next_rdata : `IEM_RST_WORD;
      end
   end

   // every read is answered, refused or not, so the host never waits on it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_read;
      end
   end
endmodule // iem_top
`default_nettype wire

// File: iem_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "iem_map.svh"
module iem_assertions (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic spi_mode,
   input wire logic reg_write,
   input wire iem_pkg::iem_addr_t reg_write_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_read,
   input wire iem_pkg::iem_addr_t reg_read_addr,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic [2:0] power_mode_select,
   input wire logic ext_write_busy,
   input wire logic ext_read_busy
);
   import iem_pkg::*;
   logic lp;
   logic rd_go;
   logic wr_go;
   assign lp = (power_mode_select >= `IEM_LP_MODE_MIN) && (power_mode_select <= `IEM_LP_MODE_MAX);
   assign rd_go = reg_write && reg_write_addr == `IEM_A_RD_CTRL && reg_wdata[`IEM_GO_BIT-8];
   assign wr_go = reg_write && reg_write_addr == `IEM_A_WR_CTRL && reg_wdata[`IEM_GO_BIT-8];
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ****************************************
   // assertions
   // ****************************************
   read_answered_a: assert property (reg_read |=> reg_rvalid)
      else $error("read not answered");
   rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_read))
      else $error("read answer without request");
   read_go_a: assert property (rd_go && !lp && !ext_read_busy |=> ext_read_busy)
      else $error("read go did not set busy");
   write_go_a: assert property (wr_go && !lp && !ext_write_busy |=> ext_write_busy)
      else $error("write go did not set busy");
   lp_go_blocked_a: assert property (rd_go && lp && !ext_read_busy |=> !ext_read_busy)
      else $error("low power write was taken");
   go_reads_zero_a: assert property (
      reg_read && (reg_read_addr[5:1] == 5'h04 || reg_read_addr[5:1] == 5'h06)
      |=> !reg_rdata[15]) else $error("go bit read back as one");
   rd_busy_bit_a: assert property (
      reg_read && reg_read_addr[5:1] == 5'h06 && !lp
      |=> reg_rdata[8] == $past(ext_read_busy)) else $error("read busy bit wrong");
   wr_busy_bit_a: assert property (
      reg_read && reg_read_addr[5:1] == 5'h04 && !lp
      |=> reg_rdata[8] == $past(ext_write_busy)) else $error("write busy bit wrong");
   read_bounded_a: assert property ($rose(ext_read_busy) |-> ##[1:20] !ext_read_busy)
      else $error("extended read too slow");
   lp_read_block_a: assert property (
      reg_read && lp && reg_read_addr < 6'h12
      |=> reg_rdata == 16'h0000) else $error("low power read not refused");
   cover property (ext_read_busy ##1 !ext_read_busy);
   cover property (ext_write_busy ##1 !ext_write_busy);
   cover property (lp && reg_write);
   cover property (lp && spi_mode && reg_read);
endmodule // iem_assertions
bind iem_top iem_assertions i_chk (.clk(clk), .reset_n(reset_n), .spi_mode(spi_mode),
   .reg_write(reg_write), .reg_write_addr(reg_write_addr), .reg_wdata(reg_wdata),
   .reg_read(reg_read), .reg_read_addr(reg_read_addr), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .power_mode_select(power_mode_select),
   .ext_write_busy(ext_write_busy), .ext_read_busy(ext_read_busy));
`default_nettype wire

// File: iem_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module iem_host_model (
   input wire logic clk,
   output logic reg_write,
   output iem_pkg::iem_addr_t reg_write_addr,
   output logic [7:0] reg_wdata,
   output logic reg_read,
   output iem_pkg::iem_addr_t reg_read_addr,
   input wire logic [15:0] reg_rdata
);
   import iem_pkg::*;
   initial begin
      reg_write = 1'b0;
      reg_write_addr = 6'h00;
      reg_wdata = 8'h00;
      reg_read = 1'b0;
      reg_read_addr = 6'h00;
   end
   // one byte per packet; idle lines show the inverse so stale values never look valid
   task automatic wr(input iem_addr_t a, input logic [7:0] d);
      @(posedge clk);
      reg_write <= 1'b1;
      reg_write_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 1'b0;
      reg_write_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   // ext_check reads the data words only after done is seen; the reset sweep reads them before any done
   task automatic rd(input iem_addr_t a, output logic [15:0] d);
      @(posedge clk);
      reg_read <= 1'b1;
      reg_read_addr <= a;
      @(posedge clk);
      reg_read <= 1'b0;
      reg_read_addr <= ~a;
      #1;
      d = reg_rdata;
   endtask
endmodule // iem_host_model
`default_nettype wire

// File: indirect_extended_memory_access_bench.sv
`timescale 1ns/1ps
`default_nettype none
module indirect_extended_memory_access_bench;
   import iem_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic spi_mode = 1'b0;
   logic reg_write, reg_read, reg_rvalid, ext_write_busy, ext_read_busy;
   iem_addr_t reg_write_addr, reg_read_addr;
   logic [7:0] reg_wdata;
   logic [15:0] reg_rdata, w, hi, lo;
   logic [2:0] power_mode_select, m;
   iem_word_t exp_mem [iem_ext_addr_t];
   iem_ext_addr_t a;
   iem_word_t d;
   logic [7:0] last;
   int mismatches = 0;
   int num_checks = 0;
   int seed = 51925;
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
   $display("Error at %0t ns: got %h expected %h", $time, got, exp); end end
   always #5 clk = ~clk;
   iem_top i_dut (.clk(clk), .reset_n(reset_n), .spi_mode(spi_mode), .reg_write(reg_write),
      .reg_write_addr(reg_write_addr), .reg_wdata(reg_wdata), .reg_read(reg_read),
      .reg_read_addr(reg_read_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .power_mode_select(power_mode_select), .ext_write_busy(ext_write_busy),
      .ext_read_busy(ext_read_busy));
   iem_host_model i_host (.clk(clk), .reg_write(reg_write), .reg_write_addr(reg_write_addr),
      .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_read_addr(reg_read_addr),
      .reg_rdata(reg_rdata));
   function automatic logic [15:0] status_word(input logic busy, input logic done);
      return {7'h00, busy, 7'h00, done};
   endfunction
   task automatic give_verdict();
      if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ****************************************
   // extended access sequences
   // ****************************************
   task automatic wait_done(input iem_addr_t sa);
      logic [15:0] s;
      int n;
      for (n = 0; n < 1200; n++) begin
         i_host.rd(sa, s);
         if (n == 0) `CHK(s, status_word(1'b1, 1'b0))
         if (s[0] === 1'b1) break;
      end
      `CHK(s, status_word(1'b0, 1'b1))
   endtask
   task automatic ext_write(input iem_ext_addr_t ea, input iem_word_t ed);
      i_host.wr(6'h03, ea);
      i_host.wr(6'h04, ed[31:24]);
      i_host.wr(6'h05, ed[23:16]);
      i_host.wr(6'h06, ed[15:8]);
      i_host.wr(6'h07, ed[7:0]);
      i_host.wr(6'h08, 8'h80);
      #1 `CHK(ext_write_busy, 1'b1)
      wait_done(6'h08);
      exp_mem[ea] = ed;
   endtask
   task automatic ext_check(input iem_ext_addr_t ea);
      i_host.wr(6'h0b, ea);
      i_host.wr(6'h0c, 8'h80);
      #1 `CHK(ext_read_busy, 1'b1)
      wait_done(6'h0c);
      i_host.rd(6'h0e, hi);
      i_host.rd(6'h10, lo);
      `CHK(hi, exp_mem[ea][31:16])
      `CHK(lo, exp_mem[ea][15:0])
   endtask
   initial begin
      #600_000;
      mismatches++;
      give_verdict();
   end
   initial begin
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         i_host.rd(6'(2 * i), w);
         `CHK(w, 16'h0000)
         `CHK(reg_rvalid, 1'b1)
      end
      // trim, an eeprom/shadow pair and the space end first, then random traffic above the eeprom
      for (int i = 0; i < 12; i++) begin
         case (i)
            0: a = 8'h07;
            1: a = 8'h12;
            2: a = 8'h1f;
            3: a = 8'h3f;
            4: a = 8'hff;
            default: a = 8'h20 | 8'($random(seed));
         endcase
         d = $random(seed);
         @(posedge clk);
         spi_mode <= d[0];
         ext_write(a, d);
         ext_check(a);
      end
      foreach (exp_mem[k]) ext_check(k);
      i_host.wr(6'h03, 8'h11);
      last = 8'h11;
      for (int i = 2; i < 8; i++) begin
         @(posedge clk);
         spi_mode <= i[0];
         m = i[2:0];
         i_host.wr(6'h33, {5'h00, m});
         i_host.wr(6'h03, {5'h08, m});
         if (m < 3'h3 || m > 3'h6) last = {5'h08, m};
         i_host.rd(6'h32, w);
         `CHK(w, {13'h0000, m})
         `CHK(power_mode_select, m)
         i_host.rd(6'h02, w);
         `CHK(w, (m >= 3'h3 && m <= 3'h6) ? 16'h0000 : {8'h00, last})
         if (m >= 3'h3 && m <= 3'h6) begin
            i_host.wr(6'h0c, 8'h80);
            #1 `CHK(ext_read_busy, 1'b0)
         end
      end
      i_host.wr(6'h33, 8'h00);
      i_host.rd(6'h02, w);
      `CHK(w, {8'h00, last})
      give_verdict();
   end
endmodule // indirect_extended_memory_access_bench
`default_nettype wire
